// ---- common/bccr_map.svh ----
// Register offsets, field positions, reset values and bus address of the board config register bank
`ifndef BCCR_MAP_SVH
`define BCCR_MAP_SVH

// Target address on the dedicated configuration bus (0b1101000)
`define BCCR_DEV_ADDR         7'h68

// Register offsets
`define BCCR_OFS_CLKGEN_IRQ   8'h01
`define BCCR_OFS_PORT_FIRST   8'h02
`define BCCR_OFS_PORT_LAST    8'h05
`define BCCR_OFS_MODULE_CTRL  8'h06

// Clock generator status fields
`define BCCR_BIT_SYS_IRQ      4
`define BCCR_BIT_USR_IRQ      0

// Port buffer control fields
`define BCCR_BIT_FAILSAFE     4
`define BCCR_BIT_TX_EN        1
`define BCCR_BIT_RX_EN        0

// Optical module control fields
`define BCCR_BIT_M1_RS_HI     7
`define BCCR_BIT_M1_RS_LO     6
`define BCCR_BIT_M1_TXDIS     4
`define BCCR_BIT_M0_RS_HI     3
`define BCCR_BIT_M0_RS_LO     2
`define BCCR_BIT_M0_TXDIS     0

// Reset values
`define BCCR_RST_PORT_CTRL    3'h0
`define BCCR_RST_MODULE_CTRL  4'h0
`define BCCR_RST_MIRROR       1'h0

`endif

// ---- common/bccr_pkg.sv ----
// Types shared by the board config register bank
package bccr_pkg;

  // Serial target protocol phases
  typedef enum logic [2:0] {
    BCCR_IDLE,
    BCCR_ADDR,
    BCCR_ACK,
    BCCR_WRITE,
    BCCR_READ,
    BCCR_MACK
  } bccr_phase_t;

  // Control bits of one backplane port buffer
  typedef struct packed {
    logic failsafe_receiver_select;
    logic tx_pair_driver_enable;
    logic rx_pair_driver_enable;
  } bccr_port_ctrl_t;

  // Four ports, index 0 is port 17
  typedef bccr_port_ctrl_t [3:0] bccr_port_ctrl_arr_t;

  // Writable optical module control pins
  typedef struct packed {
    logic       module1_transmit_disable;
    logic [1:0] module0_rate_select;
    logic       module0_transmit_disable;
  } bccr_module_ctrl_t;

  // Complete state of the register bank
  typedef struct packed {
    logic                scl;
    logic                sda;
    bccr_phase_t         phase;
    logic [3:0]          bitcnt;
    logic [7:0]          shreg;
    logic                rw;
    logic                first;
    logic                nack;
    logic [7:0]          ptr;
    logic                sda_o;
    logic                sda_oe_n;
    logic                system_clkgen_irq_level;
    logic                user_clkgen_irq_level;
    logic [1:0]          module1_rate_select;
    bccr_port_ctrl_arr_t port;
    bccr_module_ctrl_t   modc;
  } bccr_state_t;

endpackage

// ---- dv/bccr_checker.sv ----
// Port assertions for the board config register bank
`timescale 1ns/10ps
module bccr_checker (
  input wire logic                          i_core_clk,    // Core clock
  input wire logic                          i_srst,        // Sync reset
  input wire logic                          i_scl,         // Serial clock
  input wire logic                          i_sda,         // Data line
  input wire logic                          o_sda,         // Data drive value
  input wire logic                          o_sda_oe_n,    // Data drive enable
  input wire bccr_pkg::bccr_port_ctrl_arr_t o_port_ctrl,   // Port controls
  input wire bccr_pkg::bccr_module_ctrl_t   o_module_ctrl  // Module pins
);
  import bccr_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Acknowledge must stay driven for five core cycles once it starts
  sequence ack_held;
    !o_sda_oe_n [*5];
  endsequence
  // Master start: data falls while clock stays high
  sequence start_seen;
    $fell(i_sda) && i_scl && $past(i_scl);
  endsequence
  rst_values_a: assert property ($fell(i_srst) |-> o_port_ctrl == '0 && o_module_ctrl == '0 && o_sda_oe_n)
    else $error("outputs not at reset values");
  sda_low_a: assert property (o_sda == 1'b0)
    else $error("data drive value not low");
  drive_edge_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data drive changed while clock high");
  ack_hold_a: assert property ($fell(o_sda_oe_n) |-> ack_held)
    else $error("data drive released too early");
  start_free_a: assert property (start_seen |-> o_sda_oe_n)
    else $error("target drives data at a start");
  port_on_ack_a: assert property ($changed(o_port_ctrl) |-> !o_sda_oe_n && !i_scl)
    else $error("port control changed outside a write ack");
  mod_on_ack_a: assert property ($changed(o_module_ctrl) |-> !o_sda_oe_n && !i_scl)
    else $error("module control changed outside a write ack");
  one_target_a: assert property (!($changed(o_port_ctrl) && $changed(o_module_ctrl)))
    else $error("one byte updated two registers");
endmodule // bccr_checker

bind bccr_regs bccr_checker bccr_checker_i (.i_core_clk, .i_srst, .i_scl, .i_sda, .o_sda, .o_sda_oe_n,
  .o_port_ctrl, .o_module_ctrl);

// ---- dv/bccr_master.sv ----
// Serial bus master model that reaches the register bank
`timescale 1ns/10ps
module bccr_master (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_sda,      // Resolved data line
  output logic      o_scl,      // Serial clock, idles high
  output logic      o_sda_low   // High pulls data low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Four core cycles per step keeps setup and hold well above one cycle
  task automatic wt();
    repeat (4) @(negedge i_core_clk);
  endtask
  // Start or repeated start, clock stands low afterwards
  task automatic start();
    o_sda_low = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = 1'b1;
    wt();
    o_scl = 1'b0;
    wt();
  endtask
  // Stop, clock then stands high until the next frame
  task automatic stop();
    o_sda_low = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = 1'b0;
    wt();
  endtask
  // One bit; a 1 releases the line so the target may drive it
  task automatic bitx(input logic b, output logic r);
    o_sda_low = !b;
    wt();
    o_scl = 1'b1;
    wt();
    r = i_sda;
    o_scl = 1'b0;
    wt();
  endtask
  // bytes MSB first, ninth bit acknowledge
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mack, ack);
  endtask
endmodule // bccr_master

// ---- dv/test_bccr_regs.sv ----
// Self-checking bench for the board config register bank
`timescale 1ns/10ps
`include "bccr_map.svh"
module test_bccr_regs;
  import bccr_pkg::*;
  typedef struct packed { logic [7:0] a, d, r; logic [11:0] p; logic [3:0] m; } bccr_row_t;
  logic                clk = 1'b0;     // Core clock
  logic                srst = 1'b1;    // Sync reset
  logic                scl, m_low;     // Master side of the bus
  logic                sda;            // Resolved data line, pulled up
  logic                oe_n, sda_o;    // Target drive
  logic                irq_s = 1'b0;   // System irq pin
  logic                irq_u = 1'b0;   // User irq pin
  logic [1:0]          rs1 = 2'b10;    // Module1 rate pins
  bccr_port_ctrl_arr_t port;           // Port controls
  bccr_module_ctrl_t   modc;           // Module pins
  int                  fail_count = 0; // Mismatches
  int                  checks = 0;     // Comparisons
  int                  cyc = 0;        // Cycle count
  logic [7:0]          q;              // Read data
  logic                ak;             // Ack seen, low means acked
  // Offset, write, read back, expected pins; state carries from row to row
  bccr_row_t rows [9] = '{
    '{8'h02, 8'hFF, 8'h13, 12'h007, 4'h0},
    '{8'h03, 8'h12, 8'h12, 12'h037, 4'h0},
    '{8'h04, 8'h01, 8'h01, 12'h077, 4'h0},
    '{8'h05, 8'h10, 8'h10, 12'h877, 4'h0},
    '{8'h06, 8'hFF, 8'h9D, 12'h877, 4'hF},
    '{8'h06, 8'h04, 8'h84, 12'h877, 4'h2},
    '{8'h01, 8'hFF, 8'h00, 12'h877, 4'h2},
    '{8'h00, 8'hFF, 8'h00, 12'h877, 4'h2},
    '{8'h07, 8'hFF, 8'h00, 12'h877, 4'h2}
  };
  always #20 clk = ~clk;
  // Open-drain line: low if either party pulls
  assign sda = (oe_n ? 1'b1 : sda_o) & ~m_low;
  bccr_regs bccr_regs_i (.i_core_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .o_sda(sda_o),
    .o_sda_oe_n(oe_n), .i_system_clkgen_irq_level(irq_s), .i_user_clkgen_irq_level(irq_u),
    .i_module1_rate_select(rs1), .o_port_ctrl(port), .o_module_ctrl(modc));
  bccr_master bccr_master_i (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
  task automatic cmp_rd(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_pin(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Single byte write framed by start and stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR, 1'b0}, 1'b1, x, ak);
    bccr_master_i.xfer(a, 1'b1, x, ak);
    bccr_master_i.xfer(d, 1'b1, x, ak);
    cmp_rd("write ack", 8'h00, {7'h00, ak});
    bccr_master_i.stop();
  endtask
  // Pointer write, repeated start, one byte read ended by a NACK
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic x;
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR, 1'b0}, 1'b1, d, x);
    bccr_master_i.xfer(a, 1'b1, d, x);
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR, 1'b1}, 1'b1, d, x);
    bccr_master_i.xfer(8'hFF, 1'b1, d, x);
    bccr_master_i.stop();
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hang short; a full run needs about 13000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    cmp_pin("reset pins", 16'h0000, {modc, port});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      cmp_rd("read back", rows[i].r, q);
      cmp_pin("pins", {rows[i].m, rows[i].p}, {modc, port});
    end
    $display("test table done");
    for (int k = 0; k < 4; k++) begin
      {irq_s, irq_u} = k[1:0];
      rs1 = k[1:0];
      rd(8'h01, q);
      cmp_rd("status", {3'h0, k[1], 3'h0, k[0]}, q);
      rd(8'h06, q);
      cmp_rd("module1 rate", {k[1:0], 6'h04}, q);
    end
    $display("test status done");
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ak);
    bccr_master_i.stop();
    cmp_rd("foreign ack", 8'h01, {7'h00, ak});
    $display("test address done");
    // Burst write checks the pointer step between ports
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR, 1'b0}, 1'b1, q, ak);
    bccr_master_i.xfer(8'h02, 1'b1, q, ak);
    bccr_master_i.xfer(8'hAA, 1'b1, q, ak);
    bccr_master_i.xfer(8'h55, 1'b1, q, ak);
    bccr_master_i.stop();
    cmp_pin("burst pins", 16'h286A, {modc, port});
    // Two-byte read with a master ACK between checks the read pointer step
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR, 1'b0}, 1'b1, q, ak);
    bccr_master_i.xfer(8'h02, 1'b1, q, ak);
    bccr_master_i.start();
    bccr_master_i.xfer({`BCCR_DEV_ADDR, 1'b1}, 1'b1, q, ak);
    bccr_master_i.xfer(8'hFF, 1'b0, q, ak);
    cmp_rd("burst read first", 8'h02, q);
    bccr_master_i.xfer(8'hFF, 1'b1, q, ak);
    cmp_rd("burst read second", 8'h11, q);
    bccr_master_i.stop();
    $display("test burst done");
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    cmp_pin("rerun reset", 16'h0000, {modc, port});
    rd(8'h06, q);
    cmp_rd("module after reset", 8'hC0, q);
    $display("test reset done");
    test_done();
  end
endmodule // test_bccr_regs

// ---- verilog/bccr_regs.sv ----
// Board config controller register bank with its serial target interface
//
// Contract
// R01: Answer serial target address 0b1101000 only
// R02: Status bit 4 mirrors system generator irq
// R03: Status bit 0 mirrors user generator irq
// R04: Four port registers at 0x02..0x05
// R05: Port bit 4 selects failsafe receiver
// R06: Port bit 1 enables TX pair driver
// R07: Port bit 0 enables RX pair driver
// R08: Module bit 0 drives module0 transmit disable
// R09: Module bit 4 drives module1 transmit disable
// R10: Module bits 3:2 drive module0 rate select
// R11: Module bits 7:6 show module1 rate select
// R12: Reserved bits read zero, writes ignored
`timescale 1ns/10ps
`include "bccr_map.svh"

module bccr_regs (
  input  wire logic                          i_core_clk,                   // Core clock, 25 MHz
  input  wire logic                          i_srst,                       // Synchronous reset, active high
  input  wire logic                          i_scl,                        // Serial clock from the master
  input  wire logic                          i_sda,                        // Serial data line level
  output logic                               o_sda,                        // Serial data drive value, always low
  output logic                               o_sda_oe_n,                   // Serial data drive enable, low drives
  input  wire logic                          i_system_clkgen_irq_level,    // System clock generator irq pin
  input  wire logic                          i_user_clkgen_irq_level,      // User clock generator irq pin
  input  wire logic [1:0]                    i_module1_rate_select,        // Module1 rate select pin states
  output bccr_pkg::bccr_port_ctrl_arr_t      o_port_ctrl,                  // Port 17..20 buffer controls
  output bccr_pkg::bccr_module_ctrl_t        o_module_ctrl                 // Optical module control pins
);
  import bccr_pkg::*;

  bccr_state_t s_q;        // Registered state
  bccr_state_t s_d;        // Next state
  logic        scl_rise;   // Serial clock rising edge
  logic        scl_fall;   // Serial clock falling edge
  logic        start_cond; // Data falls while clock high
  logic        stop_cond;  // Data rises while clock high
  logic [7:0]  port_ofs;   // Pointer relative to first port register

  // Port register window test, shared by the read and write paths so they cannot disagree
  function automatic logic in_port_range(input logic [7:0] ofs);
    return (ofs >= `BCCR_OFS_PORT_FIRST) && (ofs <= `BCCR_OFS_PORT_LAST);
  endfunction

  // Readback of one register; unmapped offsets give zero
  function automatic logic [7:0] read_reg(input logic [7:0] ofs, input bccr_state_t st);
    logic [7:0] v;
    logic [7:0] rel;
    v   = 8'h00;
    rel = ofs - `BCCR_OFS_PORT_FIRST;
    if (ofs == `BCCR_OFS_CLKGEN_IRQ) begin
      // R02: system irq mirror
      v[`BCCR_BIT_SYS_IRQ] = st.system_clkgen_irq_level;
      // R03: user irq mirror
      v[`BCCR_BIT_USR_IRQ] = st.user_clkgen_irq_level;
    end else if (in_port_range(ofs)) begin
      // R04: port register readback
      v[`BCCR_BIT_FAILSAFE] = st.port[rel[1:0]].failsafe_receiver_select;
      v[`BCCR_BIT_TX_EN]    = st.port[rel[1:0]].tx_pair_driver_enable;
      v[`BCCR_BIT_RX_EN]    = st.port[rel[1:0]].rx_pair_driver_enable;
    end else if (ofs == `BCCR_OFS_MODULE_CTRL) begin
      // R11: module1 rate select readback
      v[`BCCR_BIT_M1_RS_HI] = st.module1_rate_select[1];
      v[`BCCR_BIT_M1_RS_LO] = st.module1_rate_select[0];
      v[`BCCR_BIT_M1_TXDIS] = st.modc.module1_transmit_disable;
      v[`BCCR_BIT_M0_RS_HI] = st.modc.module0_rate_select[1];
      v[`BCCR_BIT_M0_RS_LO] = st.modc.module0_rate_select[0];
      v[`BCCR_BIT_M0_TXDIS] = st.modc.module0_transmit_disable;
    end
    return v;
  endfunction

  // Line events seen against the previous sample; pins are synchronous already
  always_comb begin
    scl_rise   = ~s_q.scl & i_scl;
    scl_fall   = s_q.scl & ~i_scl;
    start_cond = s_q.scl & i_scl & s_q.sda & ~i_sda;
    stop_cond  = s_q.scl & i_scl & ~s_q.sda & i_sda;
    port_ofs   = s_q.ptr - `BCCR_OFS_PORT_FIRST;
  end

  // Next state: line sampling, protocol sequencing and register writes
  always_comb begin
    s_d     = s_q;
    s_d.scl = i_scl;
    s_d.sda = i_sda;
    // R02: live system irq level
    s_d.system_clkgen_irq_level = i_system_clkgen_irq_level;
    // R03: live user irq level
    s_d.user_clkgen_irq_level = i_user_clkgen_irq_level;
    // R11: live module1 rate select
    s_d.module1_rate_select = i_module1_rate_select;

    if (start_cond) begin
      // Start or repeated start restarts address reception
      s_d.phase    = BCCR_ADDR;
      s_d.bitcnt   = 4'h0;
      s_d.first    = 1'b1;
      s_d.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      // Stop releases the line whatever we were doing
      s_d.phase    = BCCR_IDLE;
      s_d.sda_oe_n = 1'b1;
    end else begin
      unique case (s_q.phase)
        BCCR_IDLE: begin
          // Wait for a start
          s_d.sda_oe_n = 1'b1;
        end
        BCCR_ADDR, BCCR_WRITE: begin
          // Shift in on rising clock, MSB first
          if (scl_rise && s_q.bitcnt != 4'h8) begin
            s_d.shreg  = {s_q.shreg[6:0], i_sda};
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end else if (scl_fall && s_q.bitcnt == 4'h8) begin
            s_d.bitcnt = 4'h0;
            if (s_q.phase == BCCR_ADDR) begin
              // R01: match own address
              if (s_q.shreg[7:1] == `BCCR_DEV_ADDR) begin
                s_d.rw       = s_q.shreg[0];
                s_d.phase    = BCCR_ACK;
                s_d.sda_oe_n = 1'b0;
              end else begin
                // Other address: stay off the line until next start
                s_d.phase = BCCR_IDLE;
              end
            end else begin
              s_d.phase    = BCCR_ACK;
              s_d.sda_oe_n = 1'b0;
              if (s_q.first) begin
                // First byte after address loads the pointer
                s_d.ptr   = s_q.shreg;
                s_d.first = 1'b0;
              end else begin
                s_d.ptr = s_q.ptr + 8'h01;
                // R04: four port registers
                if (in_port_range(s_q.ptr)) begin
                  // R05: failsafe select write
                  s_d.port[port_ofs[1:0]].failsafe_receiver_select = s_q.shreg[`BCCR_BIT_FAILSAFE];
                  // R06: TX enable write
                  s_d.port[port_ofs[1:0]].tx_pair_driver_enable = s_q.shreg[`BCCR_BIT_TX_EN];
                  // R07: RX enable write
                  s_d.port[port_ofs[1:0]].rx_pair_driver_enable = s_q.shreg[`BCCR_BIT_RX_EN];
                end else if (s_q.ptr == `BCCR_OFS_MODULE_CTRL) begin
                  // R08: module0 transmit disable
                  s_d.modc.module0_transmit_disable = s_q.shreg[`BCCR_BIT_M0_TXDIS];
                  // R09: module1 transmit disable
                  s_d.modc.module1_transmit_disable = s_q.shreg[`BCCR_BIT_M1_TXDIS];
                  // R10: module0 rate select
                  s_d.modc.module0_rate_select = s_q.shreg[`BCCR_BIT_M0_RS_HI:`BCCR_BIT_M0_RS_LO];
                end
                // R12: other bits and offsets dropped
              end
            end
          end
        end
        BCCR_ACK: begin
          // Acknowledge is held until the next falling clock, through one clock high phase
          if (scl_fall) begin
            s_d.bitcnt   = 4'h0;
            s_d.sda_oe_n = 1'b1;
            if (s_q.rw) begin
              // Load read data and present the MSB at once
              s_d.shreg    = read_reg(s_q.ptr, s_q);
              s_d.ptr      = s_q.ptr + 8'h01;
              s_d.sda_oe_n = s_d.shreg[7];
              s_d.bitcnt   = 4'h1;
              s_d.phase    = BCCR_READ;
            end else begin
              s_d.phase = BCCR_WRITE;
            end
          end
        end
        BCCR_READ: begin
          // Each falling clock shifts the next bit out; after bit 0 let go
          if (scl_fall) begin
            if (s_q.bitcnt == 4'h8) begin
              s_d.sda_oe_n = 1'b1;
              s_d.phase    = BCCR_MACK;
            end else begin
              s_d.shreg    = {s_q.shreg[6:0], 1'b0};
              s_d.sda_oe_n = s_q.shreg[6];
              s_d.bitcnt   = s_q.bitcnt + 4'h1;
            end
          end
        end
        BCCR_MACK: begin
          // Master acknowledge decides whether another byte follows
          if (scl_rise) begin
            s_d.nack = i_sda;
          end else if (scl_fall) begin
            if (s_q.nack) begin
              // Not acknowledged: stay released until stop or start
              s_d.phase = BCCR_IDLE;
            end else begin
              s_d.shreg    = read_reg(s_q.ptr, s_q);
              s_d.ptr      = s_q.ptr + 8'h01;
              s_d.sda_oe_n = s_d.shreg[7];
              s_d.bitcnt   = 4'h1;
              s_d.phase    = BCCR_READ;
            end
          end
        end
      endcase
    end
  end

  // State register; idle lines are taken as high so reset sees no false start
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s_q.scl      <= 1'b1;
      s_q.sda      <= 1'b1;
      s_q.phase    <= BCCR_IDLE;
      s_q.bitcnt   <= 4'h0;
      s_q.shreg    <= 8'h00;
      s_q.rw       <= 1'b0;
      s_q.first    <= 1'b1;
      s_q.nack     <= 1'b1;
      s_q.ptr      <= 8'h00;
      s_q.sda_o    <= 1'b0;
      s_q.sda_oe_n <= 1'b1;
      s_q.system_clkgen_irq_level <= `BCCR_RST_MIRROR;
      s_q.user_clkgen_irq_level   <= `BCCR_RST_MIRROR;
      s_q.module1_rate_select     <= {2{`BCCR_RST_MIRROR}};
      s_q.port     <= {4{`BCCR_RST_PORT_CTRL}};
      s_q.modc     <= `BCCR_RST_MODULE_CTRL;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  always_comb begin
    o_sda         = s_q.sda_o;
    o_sda_oe_n    = s_q.sda_oe_n;
    o_port_ctrl   = s_q.port;
    o_module_ctrl = s_q.modc;
  end

endmodule // bccr_regs
